// ---- tb/rfq_fetch_tb.sv ----
// self-checking bench for the free queue fetch engine
`include "rfq_consts.svh"
module rfq_fetch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rfq_pkg::*;
   logic mclk_i = 0, rstn_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, breq = 0, bsmall = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, mrd_v, mrd_rdy, mrd_dv, brdy;
   logic ans_v, ans_e;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, mrd_addr, mrd_data, ans_addr, got;
   logic [1:0] bresp, rresp, resp, wresp;
   logic [5:0] mrd_dw;
   logic [15:0] ans_ptr, base;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   rfq_fetch u_rfq_fetch (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .mrd_req_valid_o(mrd_v),
      .mrd_req_ready_i(mrd_rdy), .mrd_req_addr_o(mrd_addr), .mrd_req_dwords_o(mrd_dw),
      .mrd_data_valid_i(mrd_dv), .mrd_data_i(mrd_data), .buf_req_valid_i(breq),
      .buf_req_small_i(bsmall), .buf_req_ready_o(brdy), .buf_ans_valid_o(ans_v),
      .buf_ans_err_o(ans_e), .buf_ans_addr_o(ans_addr), .buf_ans_ptr_o(ans_ptr),
      .irq_o(irq));
   rfq_host_mem u_rfq_host_mem (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_valid_i(mrd_v),
      .req_addr_i(mrd_addr), .req_dwords_i(mrd_dw), .req_ready_o(mrd_rdy),
      .data_valid_o(mrd_dv), .data_o(mrd_data));
   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard; the whole run needs a few hundred cycles
   initial
   begin
      forever #2 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // descriptor address in host memory, start index fixed at 8
   function automatic logic [31:0] ea(input logic s, input logic [15:0] rp);
      return {16'h0000, base} + ({16'h0000, (s ? 16'h0008 : 16'h0000)} + rp) * 8;
   endfunction
   // handshakes are judged at the falling edge, acted on at the rising one
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(negedge mclk_i);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bready && bvalid;
         wresp = bresp;
         @(posedge mclk_i);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (tb) bready <= 0;
      end
      while (!tb);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do
      begin
         @(negedge mclk_i);
         ta = arvalid && arready;
         tr = rready && rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk_i);
         if (ta) arvalid <= 0;
         if (tr) rready <= 0;
      end
      while (!tr);
   endtask
   task automatic poll(input logic [11:0] a, input logic [31:0] e);
      repeat (60)
      begin
         rd(a, got, resp);
         if (got === e) break;
      end
      chk(got, e);
   endtask
   // one channel request; answer lands the cycle after the take
   task automatic take(input logic s, input logic e, input logic [31:0] a);
      logic t;
      @(posedge mclk_i);
      breq <= 1;
      bsmall <= s;
      do
      begin
         @(negedge mclk_i);
         t = brdy;
         @(posedge mclk_i);
         if (t) breq <= 0;
      end
      while (!t);
      @(negedge mclk_i);
      chk({31'h0, ans_v}, 32'h1);
      chk({31'h0, ans_e}, {31'h0, e});
      if (!e) chk(ans_addr, a ^ 32'hC3C30000);
      if (!e) chk({16'h0, ans_ptr}, (a + 32'h4) & 32'hFFFF);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(31));
      base = 16'h1000 | (16'($urandom) & 16'h0FF8);
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1;
      rd(`RFQ_OFS_QCTL, got, resp);
      chk(got, 32'h0);
      wr(`RFQ_OFS_QCTL, 32'hFFFF);
      poll(`RFQ_OFS_QCTL, 32'h073D);
      wr(`RFQ_OFS_QCTL, 32'h0);
      chk({30'h0, wresp}, 32'h0);
      wr(12'h7A0, 32'h0);
      chk({30'h0, wresp}, 32'h2);
      rd(12'h7A0, got, resp);
      chk({30'h0, resp}, 32'h2);
      wr(`RFQ_OFS_BASE_LO, {16'h0, base});
      wr(`RFQ_OFS_BASE_HI, 32'h0);
      wr(`RFQ_OFS_END, 32'd12);
      wr(`RFQ_OFS_SMALL_QUEUE_START, 32'd8);
      wr(`RFQ_OFS_IRQEN, 32'h4);
      wr(`RFQ_OFS_DMACTL, 32'h1);
      take(0, 1, 0);
      rd(`RFQ_OFS_STATUS, got, resp);
      chk(got & 32'h4, 32'h4);
      chk({31'h0, irq}, 32'h1);
      wr(`RFQ_OFS_STATUS, 32'hF);
      chk({31'h0, irq}, 32'h0);
      wr(`RFQ_OFS_LWP, 32'd3);
      for (int i = 0; i < 3; i++) take(0, 0, ea(0, 16'(i)));
      poll(`RFQ_OFS_LRP, 32'd3);
      rd(`RFQ_OFS_STATUS, got, resp);
      chk(got & 32'h1, 32'h1);
      wr(`RFQ_OFS_LRP, 32'd6);
      wr(`RFQ_OFS_LWP, 32'd1);
      for (int i = 6; i < 9; i++) take(0, 0, ea(0, 16'(i % 8)));
      poll(`RFQ_OFS_LRP, 32'd1);
      wr(`RFQ_OFS_SRP, 32'd3);
      wr(`RFQ_OFS_SWP, 32'd1);
      take(1, 0, ea(1, 3));
      take(1, 0, ea(1, 0));
      rd(`RFQ_OFS_STATUS, got, resp);
      chk(got & 32'h2, 32'h2);
      // burst refill: large holds 7, small holds 3 (no wrap crossing)
      wr(`RFQ_OFS_LRP, 32'd0);
      wr(`RFQ_OFS_LWP, 32'd7);
      wr(`RFQ_OFS_SRP, 32'd0);
      wr(`RFQ_OFS_SWP, 32'd3);
      wr(`RFQ_OFS_QCTL, 32'h1);
      poll(`RFQ_OFS_LRP, 32'd7);
      poll(`RFQ_OFS_SRP, 32'd3);
      take(0, 0, ea(0, 0));
      take(0, 0, ea(0, 1));
      take(1, 0, ea(1, 0));
      wr(`RFQ_OFS_QCTL, 32'h5);
      wr(`RFQ_OFS_QCTL, 32'h1);
      take(0, 1, 0);
      wr(`RFQ_OFS_QCTL, 32'h9);
      wr(`RFQ_OFS_QCTL, 32'h1);
      take(1, 1, 0);
      // single queue: sixteen-entry store, watermark four, burst stops at wrap
      wr(`RFQ_OFS_SMALL_QUEUE_START, 32'd12);
      wr(`RFQ_OFS_LWP, 32'd3);
      poll(`RFQ_OFS_LRP, 32'd0);
      take(0, 0, ea(0, 7));
      poll(`RFQ_OFS_LRP, 32'd3);
      take(1, 1, 0);
      results();
   end
endmodule

// ---- tb/rfq_host_mem.sv ----
// host memory model answering descriptor burst reads
module rfq_host_mem (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // burst request from the fetch engine
   input wire logic req_valid_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [5:0] req_dwords_i,
   output logic req_ready_o,
   // returned dwords
   output logic data_valid_o,
   output logic [31:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ptr_q;
   logic [5:0] left_q;
   ////////////////////////////////////////////////////////////////////////////
   // memory word is its own address xored with a marker; gaps are random
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         req_ready_o <= 1'b0;
         data_valid_o <= 1'b0;
         data_o <= 32'h00000000;
         ptr_q <= 32'h00000000;
         left_q <= 6'h00;
      end
      else
      begin
         // released data line toggles so a stale value never looks valid
         data_valid_o <= 1'b0;
         data_o <= ~data_o;
         req_ready_o <= (left_q == 6'h00) && req_valid_i && !req_ready_o
            && ($urandom_range(0, 1) == 1);
         if (req_ready_o && req_valid_i)
         begin
            left_q <= req_dwords_i;
            ptr_q <= req_addr_i;
         end
         else if (left_q != 6'h00 && $urandom_range(0, 2) != 0)
         begin
            data_valid_o <= 1'b1;
            data_o <= ptr_q ^ 32'hC3C30000;
            ptr_q <= ptr_q + 32'h00000004;
            left_q <= left_q - 6'h01;
         end
      end
   end
endmodule

// ---- verilog/rfq_consts.svh ----
// named offsets, field positions and counts for the free queue fetch block
`ifndef RFQ_CONSTS_SVH
`define RFQ_CONSTS_SVH
`define RFQ_OFS_BASE_LO 12'h700
`define RFQ_OFS_BASE_HI 12'h704
`define RFQ_OFS_END 12'h708
`define RFQ_OFS_SMALL_QUEUE_START 12'h70C
`define RFQ_OFS_LWP 12'h710
`define RFQ_OFS_SWP 12'h714
`define RFQ_OFS_LRP 12'h718
`define RFQ_OFS_SRP 12'h71C
`define RFQ_OFS_QCTL 12'h780
`define RFQ_OFS_DMACTL 12'h790
`define RFQ_OFS_STATUS 12'h794
`define RFQ_OFS_IRQEN 12'h798
`define RFQ_QCTL_PF 0
`define RFQ_QCTL_LFL 2
`define RFQ_QCTL_SFL 3
`define RFQ_QCTL_MASK 16'h073D
`define RFQ_RST16 16'h0000
`define RFQ_FLAG_LRD 0
`define RFQ_FLAG_SRD 1
`define RFQ_FLAG_LERR 2
`define RFQ_FLAG_SERR 3
`define RFQ_ENTRY_SHIFT 3
`define RFQ_DW_PER_DESC 6'h02
`define RFQ_DEPTH 16
`define RFQ_HALF 5'h08
`define RFQ_FULL 5'h10
`define RFQ_WM_DUAL 5'h02
`define RFQ_WM_SINGLE 5'h04
`define RFQ_RESP_OKAY 2'h0
`define RFQ_RESP_SLVERR 2'h2
`endif

// ---- verilog/rfq_fetch.sv ----
// receive free queue descriptor fetch engine with prefetch store and register slave
`include "rfq_consts.svh"
// How it works
// - large queue address is base plus pointer times eight
// - small queue address is base plus small start times eight plus pointer times eight
// - small start and end are entry indices; absolute end is base plus end times eight
// - no fetch before rx dma enable; fetch address is pointer times eight added to base, plus small start times eight for the small queue
// - each taken descriptor advances its read pointer by one two-dword entry
// - advanced pointer wraps to zero at small start (large) or end (small)
// - every successful fetch sets the large or small fetch flag
// - empty queue sets the matching error flag; no read, no pointer change
// - each flag raises the interrupt line when its enable bit is set
// - prefetch store holds sixteen descriptors, each the first dword plus the low half of the second
// - small start equal to end means single queue, otherwise dual queues
// - dual mode splits the store eight and eight; single uses all sixteen
// - burst fetch only with prefetch enable bit 0 set, else one at a time
// - prefetch refills when store count reaches watermark: two dual, four single
// - burst length never exceeds what the host queue currently holds
// - after burst, pointer moves past fetched entries and fetch flag is set
// - control bit 2 set empties the large store; software clears it again
// - control bit 3 set empties the small store; software clears it again
// - control also holds done queue enable, flush and threshold bits, reset zero
// - device owns read pointers, host software owns write pointers
// - queue is empty when read pointer equals write pointer
module rfq_fetch (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // axi4-lite register slave
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // host memory burst read port
   output logic mrd_req_valid_o,
   input wire logic mrd_req_ready_i,
   output logic [31:0] mrd_req_addr_o,
   output logic [5:0] mrd_req_dwords_o,
   input wire logic mrd_data_valid_i,
   input wire logic [31:0] mrd_data_i,
   // channel buffer requests
   input wire logic buf_req_valid_i,
   input wire logic buf_req_small_i,
   output logic buf_req_ready_o,
   output logic buf_ans_valid_o,
   output logic buf_ans_err_o,
   output logic [31:0] buf_ans_addr_o,
   output logic [15:0] buf_ans_ptr_o,
   // status
   output logic irq_o
);
   import rfq_pkg::*;

   rfq_state_t st_q, st_d;
   logic pf, dual, lfl, sfl, have, deny, take, needl, needs, last;
   logic [4:0] cap, wm, ix;
   logic [15:0] llen, slen, lav, sav, lim;
   logic [32:0] rr;
   logic [47:0] ent;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge into a 16-bit register
   function automatic logic [15:0] wmerge(logic [15:0] old, logic [31:0] d, logic [3:0] s);
      wmerge = old;
      if (s[0]) wmerge[7:0] = d[7:0];
      if (s[1]) wmerge[15:8] = d[15:8];
   endfunction
   // entries the host has posted but the device has not taken
   function automatic logic [15:0] qavail(logic [15:0] wp, logic [15:0] rp, logic [15:0] len);
      qavail = (wp >= rp) ? wp - rp : len - rp + wp;
   endfunction
   // advance with wrap to zero at the queue length
   function automatic logic [15:0] padv(logic [15:0] rp, logic [15:0] k, logic [15:0] len);
      padv = rp + k;
      if (padv >= len) padv = `RFQ_RST16;
   endfunction
   // store slot inside a partition of size cap
   function automatic logic [4:0] slot(logic [4:0] b, logic [4:0] h, logic [4:0] o,
                                       logic [4:0] c);
      logic [4:0] i;
      i = h + o;
      if (i >= c) i = i - c;
      slot = b + i;
   endfunction
   // absolute byte address of an entry
   function automatic logic [31:0] fq_addr(logic [31:0] base, logic [15:0] start,
                                           logic [15:0] ptr);
      logic [31:0] e;
      e = {16'h0000, start} + {16'h0000, ptr};
      fq_addr = base + (e << `RFQ_ENTRY_SHIFT);
   endfunction

   // register read mux: bit 32 flags a mapped address
   function automatic logic [32:0] rd_reg(logic [11:0] a, rfq_state_t s);
      rd_reg = {1'b1, 32'h0000_0000};
      case (a)
         `RFQ_OFS_BASE_LO: rd_reg[15:0] = s.base_lo;
         `RFQ_OFS_BASE_HI: rd_reg[15:0] = s.base_hi;
         `RFQ_OFS_END: rd_reg[15:0] = s.end_idx;
         `RFQ_OFS_SMALL_QUEUE_START: rd_reg[15:0] = s.small_queue_start;
         `RFQ_OFS_LWP: rd_reg[15:0] = s.lwp;
         `RFQ_OFS_SWP: rd_reg[15:0] = s.swp;
         `RFQ_OFS_LRP: rd_reg[15:0] = s.lrp;
         `RFQ_OFS_SRP: rd_reg[15:0] = s.srp;
         `RFQ_OFS_QCTL: rd_reg[15:0] = s.qctl;
         `RFQ_OFS_DMACTL: rd_reg[0] = s.dma_en;
         `RFQ_OFS_STATUS: rd_reg[3:0] = s.flags;
         `RFQ_OFS_IRQEN: rd_reg[3:0] = s.irq_en;
         default: rd_reg[32] = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb
   begin
      st_d = st_q;
      ix = 5'h00;
      ent = 48'h0;
      rr = rd_reg(s_axi_araddr_i, st_q);
      pf = st_q.qctl[`RFQ_QCTL_PF];
      lfl = st_q.qctl[`RFQ_QCTL_LFL];
      sfl = st_q.qctl[`RFQ_QCTL_SFL];
      dual = st_q.small_queue_start != st_q.end_idx;
      cap = dual ? `RFQ_HALF : `RFQ_FULL;
      wm = dual ? `RFQ_WM_DUAL : `RFQ_WM_SINGLE;
      // queue lengths come from indices, not byte addresses
      llen = st_q.small_queue_start;
      slen = st_q.end_idx - st_q.small_queue_start;
      lav = qavail(st_q.lwp, st_q.lrp, llen);
      sav = dual ? qavail(st_q.swp, st_q.srp, slen) : `RFQ_RST16;
      st_d.ans_valid = 1'b0;
      st_d.ans_err = 1'b0;
      // write address and data are taken independently
      if (s_axi_awvalid_i && !st_q.aw_got && !st_q.bvalid)
      begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !st_q.w_got && !st_q.bvalid)
      begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata_i;
         st_d.wstrb = s_axi_wstrb_i;
      end
      if (st_q.bvalid && s_axi_bready_i) st_d.bvalid = 1'b0;
      // register write once both halves are in
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = `RFQ_RESP_OKAY;
         case (st_q.awaddr)
            `RFQ_OFS_BASE_LO: st_d.base_lo = wmerge(st_q.base_lo, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_BASE_HI: st_d.base_hi = wmerge(st_q.base_hi, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_END: st_d.end_idx = wmerge(st_q.end_idx, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_SMALL_QUEUE_START: st_d.small_queue_start = wmerge(st_q.small_queue_start, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_LWP: st_d.lwp = wmerge(st_q.lwp, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_SWP: st_d.swp = wmerge(st_q.swp, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_LRP: st_d.lrp = wmerge(st_q.lrp, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_SRP: st_d.srp = wmerge(st_q.srp, st_q.wdata, st_q.wstrb);
            `RFQ_OFS_QCTL: st_d.qctl = wmerge(st_q.qctl, st_q.wdata, st_q.wstrb)
                                       & `RFQ_QCTL_MASK;
            `RFQ_OFS_DMACTL: if (st_q.wstrb[0]) st_d.dma_en = st_q.wdata[0];
            `RFQ_OFS_STATUS: if (st_q.wstrb[0]) st_d.flags = st_q.flags & ~st_q.wdata[3:0];
            `RFQ_OFS_IRQEN: if (st_q.wstrb[0]) st_d.irq_en = st_q.wdata[3:0];
            default: st_d.bresp = `RFQ_RESP_SLVERR;
         endcase
      end
      // read answer one cycle after the address is taken
      if (st_q.rvalid && s_axi_rready_i) st_d.rvalid = 1'b0;
      if (s_axi_arvalid_i && !st_q.rvalid)
      begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rr[31:0];
         st_d.rresp = rr[32] ? `RFQ_RESP_OKAY : `RFQ_RESP_SLVERR;
      end
      // serve a channel from its own store, or refuse on an empty queue
      have = buf_req_small_i ? (st_q.scnt != 5'h00 && !sfl) : (st_q.lcnt != 5'h00 && !lfl);
      deny = !have && st_q.fsm == ST_IDLE && st_q.dma_en
             && (buf_req_small_i ? sav : lav) == `RFQ_RST16;
      take = buf_req_valid_i && (have || deny);
      if (take)
      begin
         st_d.ans_valid = 1'b1;
         if (deny)
         begin
            st_d.ans_err = 1'b1;
            st_d.flags[buf_req_small_i ? `RFQ_FLAG_SERR : `RFQ_FLAG_LERR] = 1'b1;
         end
         else if (buf_req_small_i)
         begin
            ent = st_q.store[slot(`RFQ_HALF, st_q.shead, 5'h00, cap)];
            st_d.shead = slot(5'h00, st_q.shead, 5'h01, cap);
            st_d.scnt = st_q.scnt - 5'h01;
         end
         else
         begin
            ent = st_q.store[slot(5'h00, st_q.lhead, 5'h00, cap)];
            st_d.lhead = slot(5'h00, st_q.lhead, 5'h01, cap);
            st_d.lcnt = st_q.lcnt - 5'h01;
         end
         st_d.ans_addr = ent[47:16];
         st_d.ans_ptr = ent[15:0];
      end
      // without prefetch only a waiting request pulls one descriptor
      needl = !lfl && (pf ? st_q.lcnt <= wm
                          : st_q.lcnt == 5'h00 && buf_req_valid_i && !buf_req_small_i);
      needs = dual && !sfl && (pf ? st_q.scnt <= wm
                          : st_q.scnt == 5'h00 && buf_req_valid_i && buf_req_small_i);
      last = st_q.fbeat == ({st_q.fn, 1'b0} - 6'h01);
      lim = `RFQ_RST16;
      case (st_q.fsm)
         ST_IDLE:
         begin
            if (st_q.dma_en)
            begin
               if (pf && needl && lav == `RFQ_RST16) st_d.flags[`RFQ_FLAG_LERR] = 1'b1;
               if (pf && needs && sav == `RFQ_RST16) st_d.flags[`RFQ_FLAG_SERR] = 1'b1;
               if (needl && lav != `RFQ_RST16)
               begin
                  // a burst never crosses the wrap point
                  lim = (lav < llen - st_q.lrp) ? lav : llen - st_q.lrp;
                  st_d.fn = (pf && {11'h000, cap - st_q.lcnt} < lim) ? cap - st_q.lcnt
                            : (pf ? lim[4:0] : 5'h01);
                  st_d.fq = 1'b0;
                  st_d.faddr = fq_addr({st_q.base_hi, st_q.base_lo}, `RFQ_RST16,
                                       st_q.lrp);
                  st_d.fsm = ST_ISSUE;
               end
               else if (needs && sav != `RFQ_RST16)
               begin
                  lim = (sav < slen - st_q.srp) ? sav : slen - st_q.srp;
                  st_d.fn = (pf && {11'h000, cap - st_q.scnt} < lim) ? cap - st_q.scnt
                            : (pf ? lim[4:0] : 5'h01);
                  st_d.fq = 1'b1;
                  st_d.faddr = fq_addr({st_q.base_hi, st_q.base_lo}, st_q.small_queue_start,
                                       st_q.srp);
                  st_d.fsm = ST_ISSUE;
               end
            end
         end
         ST_ISSUE:
         begin
            st_d.fbeat = 6'h00;
            if (mrd_req_ready_i) st_d.fsm = ST_DATA;
         end
         ST_DATA:
         begin
            if (mrd_data_valid_i)
            begin
               st_d.fbeat = st_q.fbeat + 6'h01;
               if (!st_q.fbeat[0])
                  st_d.dw0 = mrd_data_i;
               else if (st_q.fq)
               begin
                  ix = slot(`RFQ_HALF, st_d.shead, st_d.scnt, cap);
                  st_d.store[ix[3:0]] = {st_q.dw0, mrd_data_i[15:0]};
                  st_d.scnt = st_d.scnt + 5'h01;
               end
               else
               begin
                  ix = slot(5'h00, st_d.lhead, st_d.lcnt, cap);
                  st_d.store[ix[3:0]] = {st_q.dw0, mrd_data_i[15:0]};
                  st_d.lcnt = st_d.lcnt + 5'h01;
               end
               // pointer and flag move only once the whole burst is
               if (last)
               begin
                  st_d.fsm = ST_IDLE;
                  if (st_q.fq)
                  begin
                     st_d.srp = padv(st_q.srp, {11'h000, st_q.fn}, slen);
                     st_d.flags[`RFQ_FLAG_SRD] = 1'b1;
                  end
                  else
                  begin
                     st_d.lrp = padv(st_q.lrp, {11'h000, st_q.fn}, llen);
                     st_d.flags[`RFQ_FLAG_LRD] = 1'b1;
                  end
               end
            end
         end
         default: st_d.fsm = ST_IDLE;
      endcase
      // flush drops held entries, including one landing this cycle
      if (lfl) st_d.lcnt = 5'h00;
      if (sfl) st_d.scnt = 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready_o = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready_o = !st_q.w_got && !st_q.bvalid;
   assign s_axi_bvalid_o = st_q.bvalid;
   assign s_axi_bresp_o = st_q.bresp;
   assign s_axi_arready_o = !st_q.rvalid;
   assign s_axi_rvalid_o = st_q.rvalid;
   assign s_axi_rdata_o = st_q.rdata;
   assign s_axi_rresp_o = st_q.rresp;
   assign mrd_req_valid_o = st_q.fsm == ST_ISSUE;
   assign mrd_req_addr_o = st_q.faddr;
   assign mrd_req_dwords_o = {st_q.fn, 1'b0};
   assign buf_req_ready_o = have || deny;
   assign buf_ans_valid_o = st_q.ans_valid;
   assign buf_ans_err_o = st_q.ans_err;
   assign buf_ans_addr_o = st_q.ans_addr;
   assign buf_ans_ptr_o = st_q.ans_ptr;
   // any enabled sticky flag drives the line
   assign irq_o = |(st_q.flags & st_q.irq_en);

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_start;
      $rose(mrd_req_valid_o);
   endsequence
   sequence s_last_beat;
      st_q.fsm == ST_DATA && mrd_data_valid_i && last;
   endsequence

   property p_addr_large;
      s_start and !st_q.fq |-> mrd_req_addr_o ==
         {st_q.base_hi, st_q.base_lo} + ({16'h0000, st_q.lrp} << `RFQ_ENTRY_SHIFT);
   endproperty
   a_addr_large: assert property (p_addr_large) else $error("large fetch address wrong");
   property p_addr_small;
      s_start and st_q.fq |-> mrd_req_addr_o == {st_q.base_hi, st_q.base_lo}
         + (({16'h0000, st_q.small_queue_start} + {16'h0000, st_q.srp}) << `RFQ_ENTRY_SHIFT);
   endproperty
   a_addr_small: assert property (p_addr_small) else $error("small fetch address wrong");
   property p_no_fetch_off;
      s_start |-> $past(st_q.dma_en);
   endproperty
   a_no_fetch_off: assert property (p_no_fetch_off) else $error("fetch without dma enable");
   property p_fetch_flag;
      s_last_beat |=> st_q.flags[$past(st_q.fq) ? `RFQ_FLAG_SRD : `RFQ_FLAG_LRD];
   endproperty
   a_fetch_flag: assert property (p_fetch_flag) else $error("fetch flag not set");
   property p_deny;
      buf_req_valid_i && deny |=> buf_ans_valid_o && buf_ans_err_o
         && st_q.flags[$past(buf_req_small_i) ? `RFQ_FLAG_SERR : `RFQ_FLAG_LERR];
   endproperty
   a_deny: assert property (p_deny) else $error("empty queue not reported");
   property p_wrap;
      s_last_beat and !st_q.fq |=> st_q.lrp == `RFQ_RST16 || st_q.lrp < st_q.small_queue_start;
   endproperty
   a_wrap: assert property (p_wrap) else $error("large pointer past wrap");
   // queue select is registered with the request, availability one cycle earlier
   property p_burst_bound;
      s_start |-> {10'h000, mrd_req_dwords_o} <= {st_q.fq ? $past(sav) : $past(lav), 1'b0};
   endproperty
   a_burst_bound: assert property (p_burst_bound) else $error("burst exceeds queue");
   property p_single;
      s_start and !$past(pf) |-> mrd_req_dwords_o == `RFQ_DW_PER_DESC;
   endproperty
   a_single: assert property (p_single) else $error("burst without prefetch");
   property p_flush;
      lfl |=> st_q.lcnt == 5'h00;
   endproperty
   a_flush: assert property (p_flush) else $error("large store not flushed");
endmodule

// ---- verilog/rfq_pkg.sv ----
// types shared by the free queue fetch block
`include "rfq_consts.svh"
package rfq_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_DATA} rfq_fsm_t;
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [15:0] base_lo, base_hi, end_idx, small_queue_start, lwp, swp, lrp, srp, qctl;
      logic dma_en;
      logic [3:0] flags;
      logic [3:0] irq_en;
      logic [`RFQ_DEPTH-1:0][47:0] store;
      logic [4:0] lhead, shead, lcnt, scnt;
      rfq_fsm_t fsm;
      logic fq;
      logic [4:0] fn;
      logic [5:0] fbeat;
      logic [31:0] dw0;
      logic [31:0] faddr;
      logic ans_valid;
      logic ans_err;
      logic [31:0] ans_addr;
      logic [15:0] ans_ptr;
   } rfq_state_t;
endpackage
